//--- hw/charge_ctrl.sv
// Battery charge controller with an AHB-Lite register slave
// Functional notes
// R1: Algorithm 0 for nickel, 1 for lithium, nickel after reset.
// R2: Writing value 2 only reports current algorithm, selection unchanged.
// R3: Below 3V2 hardware charges alone while the charger is present.
// R4: Below 2V8 the transistor stays open, trickle only.
// R5: Between 2V8 and 3V2 the transistor passes pre-charge current.
// R6: Nickel: close 1000 ms, open tunable 100..10000 ms, repeating.
// R7: Not charging: sample battery at tunable idle interval, default 5000 ms.
// R8: Lower threshold default 3400 mV, upper default 4200 mV.
// R9: Nickel: at or above upper threshold, end charge, transistor open.
// R10: Lithium between 3V2 and lower threshold starts fast charge closed.
// R11: Fast charge limited to tunable duration, default 90 minutes.
// R12: Pulse phase limited to tunable duration, default 90 minutes.
// R13: Pulse charging starts only above tunable start voltage, default 4000.
// R14: Lithium pulse: close 1 s, open grows from 0.1 s to 10 s.
// R15: Lithium stops when above upper threshold after n 0.1 s periods.
// R16: Over-voltage limit for pulse charging, default 4608 mV.
// R17: Temperature supervision only with lithium algorithm.
// R18: Thermistor window 908 mV low, 2171 mV high by default.
// R19: Temperature evaluated over tunable interval, default 3.
// R20: Thermistor outside window opens transistor, stops lithium charging.
// R21: Duration limit expiry opens transistor and flags timeout.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module charge_ctrl #(
    parameter int TICK = charge_pkg::TICK_CYCLES,
    parameter int MS_PER_MIN = charge_pkg::MIN_MS
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CHARGER_INPUT,
    input wire logic [12:0] VBAT_MV,
    input wire logic VBAT_VALID,
    input wire logic [12:0] THERMISTOR_SENSE,
    input wire logic SYSTEM_ACTIVE,
    output logic SWITCH_CLOSED,
    output logic PRECHARGE_EN,
    output logic SAMPLE_REQ
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef charge_pkg::window_type window_lvl_type;

    typedef struct packed {
        logic dph;
        logic dwr;
        logic [7:0] dadr;
        logic [31:0] rdata;
        logic alg;
        logic [1:0] alg_report;
        logic [13:0] mon_ms;
        logic [13:0] idle_ms;
        window_lvl_type lvl;
        logic [12:0] pstart;
        logic [12:0] ovp;
        logic [6:0] fast_min;
        logic [6:0] pulse_min;
        charge_pkg::window_type twin;
        logic [2:0] tdelta;
        logic [6:0] nper;
        charge_pkg::phase_type ph;
        logic [31:0] tick;
        logic [13:0] ms;
        logic [13:0] open_ms;
        logic [16:0] phase_ms;
        logic [6:0] phase_min;
        logic [6:0] hi_cnt;
        logic [2:0] tcnt;
        logic done;
        logic tout;
        logic hot;
        logic ovp_hit;
        logic sample;
        logic [12:0] vbat;
    } state_type;

    state_type s_r;
    state_type s_nxt;

    localparam int CLOSE_MS_I = charge_pkg::CLOSE_MS;
    logic ms_pulse;
    logic temp_bad;
    logic fast_exp;
    logic pulse_exp;

    // Register readback mux, reused for every read
    function automatic logic [31:0] rd_mux(input state_type s,
                                           input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            charge_pkg::OFS_CTRL: v = {30'h0, s.alg_report};
            charge_pkg::OFS_STATUS: v = {20'h0, s.ovp_hit, s.hot, s.tout,
                                         s.done, 2'b00, s.ph, 1'b0,
                                         SWITCH_CLOSED, PRECHARGE_EN};
            charge_pkg::OFS_VBAT: v = {19'h0, s.vbat};
            charge_pkg::OFS_THERM: v = {19'h0, THERMISTOR_SENSE};
            charge_pkg::OFS_MONTIME: v = {18'h0, s.mon_ms};
            charge_pkg::OFS_IDLETIME: v = {18'h0, s.idle_ms};
            charge_pkg::OFS_BATLVL: v = {3'h0, s.lvl.high, 3'h0, s.lvl.low};
            charge_pkg::OFS_PULSEV: v = {3'h0, s.ovp, 3'h0, s.pstart};
            charge_pkg::OFS_LIMITS: v = {9'h0, s.nper, 1'b0, s.pulse_min,
                                         1'b0, s.fast_min};
            charge_pkg::OFS_TEMPWIN: v = {3'h0, s.twin.high, 3'h0,
                                          s.twin.low};
            charge_pkg::OFS_TDELTA: v = {29'h0, s.tdelta};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ---------------------------------------------------------------
    // Derived conditions
    // ---------------------------------------------------------------
    // Thermistor checked only on the lithium algorithm
    assign temp_bad = s_r.alg &&                                   // R17
        (THERMISTOR_SENSE < s_r.twin.low ||
         THERMISTOR_SENSE > s_r.twin.high);                        // R18
    assign ms_pulse = (s_r.tick == 32'(TICK - 1));
    assign fast_exp = s_r.phase_min >= s_r.fast_min;               // R11
    assign pulse_exp = s_r.phase_min >= s_r.pulse_min;             // R12

    // Outputs: slave is always ready, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = s_r.rdata;
    assign SWITCH_CLOSED = (s_r.ph == charge_pkg::ST_NI_CLOSE) ||
        (s_r.ph == charge_pkg::ST_LI_FAST) ||
        (s_r.ph == charge_pkg::ST_LI_CLOSE);
    assign PRECHARGE_EN = (s_r.ph == charge_pkg::ST_PRE);          // R5
    assign SAMPLE_REQ = s_r.sample;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.sample = 1'b0;
        s_nxt.rdata = 32'h0000_0000;
        // Bus data phase: writes land, reads come from the mux
        if (s_r.dph && s_r.dwr) begin
            unique case (s_r.dadr)
                charge_pkg::OFS_CTRL: begin
                    if (HWDATA[1:0] == charge_pkg::ALG_QUERY) begin
                        s_nxt.alg_report = {1'b0, s_r.alg};        // R2
                    end else if (HWDATA[1:0] == charge_pkg::ALG_NICKEL ||
                                 HWDATA[1:0] == charge_pkg::ALG_LITHIUM) begin
                        s_nxt.alg = HWDATA[0];                     // R1
                        s_nxt.alg_report = HWDATA[1:0];
                        s_nxt.ph = charge_pkg::ST_IDLE;
                    end
                end
                charge_pkg::OFS_STATUS: begin
                    s_nxt.done = s_r.done & ~HWDATA[8];
                    s_nxt.tout = s_r.tout & ~HWDATA[9];
                    s_nxt.hot = s_r.hot & ~HWDATA[10];
                    s_nxt.ovp_hit = s_r.ovp_hit & ~HWDATA[11];
                end
                charge_pkg::OFS_MONTIME: s_nxt.mon_ms = HWDATA[13:0];
                charge_pkg::OFS_IDLETIME: s_nxt.idle_ms = HWDATA[13:0];
                charge_pkg::OFS_BATLVL: begin
                    s_nxt.lvl.low = HWDATA[12:0];
                    s_nxt.lvl.high = HWDATA[28:16];
                end
                charge_pkg::OFS_PULSEV: begin
                    s_nxt.pstart = HWDATA[12:0];
                    s_nxt.ovp = HWDATA[28:16];
                end
                charge_pkg::OFS_LIMITS: begin
                    s_nxt.fast_min = HWDATA[6:0];
                    s_nxt.pulse_min = HWDATA[14:8];
                    s_nxt.nper = HWDATA[22:16];
                end
                charge_pkg::OFS_TEMPWIN: begin
                    s_nxt.twin.low = HWDATA[12:0];
                    s_nxt.twin.high = HWDATA[28:16];
                end
                charge_pkg::OFS_TDELTA: s_nxt.tdelta = HWDATA[2:0];
                default: ;
            endcase
        end
        // Address phase capture
        s_nxt.dph = HSEL && HREADY && HTRANS[1];
        s_nxt.dwr = HWRITE;
        s_nxt.dadr = HADDR[7:0];
        if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
            s_nxt.rdata = rd_mux(s_r, {HADDR[7:2], 2'b00});
        end
        if (VBAT_VALID) begin
            s_nxt.vbat = VBAT_MV;
        end
        // Millisecond time base
        if (ms_pulse) begin
            s_nxt.ms = s_r.ms + 14'h1;
            if (s_r.phase_ms == 17'(MS_PER_MIN - 1)) begin
                s_nxt.phase_ms = 17'h0;
                s_nxt.phase_min = s_r.phase_min + 7'h1;
            end else begin
                s_nxt.phase_ms = s_r.phase_ms + 17'h1;
            end
        end
        // Phase sequencing; events set flags after any clear above
        if (!CHARGER_INPUT) begin
            s_nxt.ph = charge_pkg::ST_IDLE;
        end else if (s_r.vbat < charge_pkg::MV_TRICKLE) begin
            s_nxt.ph = charge_pkg::ST_TRICKLE;                     // R4
        end else if (s_r.vbat < charge_pkg::MV_ACTIVE &&
                     !SYSTEM_ACTIVE) begin
            s_nxt.ph = charge_pkg::ST_PRE;                         // R3
        end else if (temp_bad && s_r.ph != charge_pkg::ST_IDLE &&
                     ms_pulse && s_r.tcnt >= s_r.tdelta) begin
            s_nxt.ph = charge_pkg::ST_IDLE;                        // R20
            s_nxt.hot = 1'b1;
        end else begin
            unique case (s_r.ph)
                charge_pkg::ST_IDLE, charge_pkg::ST_TRICKLE,
                charge_pkg::ST_PRE: begin
                    // Idle sampling at the idle interval
                    if (ms_pulse && s_r.ms >= s_r.idle_ms - 14'h1) begin
                        s_nxt.ms = 14'h0;
                        s_nxt.sample = 1'b1;                       // R7
                    end
                    if (!s_r.done && !s_r.tout && !temp_bad &&
                        s_r.vbat < s_r.lvl.low) begin              // R8
                        s_nxt.ms = 14'h0;
                        s_nxt.phase_ms = 17'h0;
                        s_nxt.phase_min = 7'h0;
                        s_nxt.ph = s_r.alg ? charge_pkg::ST_LI_FAST // R10
                                           : charge_pkg::ST_NI_CLOSE;
                    end
                end
                charge_pkg::ST_NI_CLOSE: begin
                    if (ms_pulse && s_r.ms == 14'(CLOSE_MS_I - 1)) begin
                        s_nxt.ms = 14'h0;
                        s_nxt.sample = 1'b1;
                        s_nxt.ph = charge_pkg::ST_NI_OPEN;         // R6
                    end
                end
                charge_pkg::ST_NI_OPEN: begin
                    if (s_r.vbat >= s_r.lvl.high) begin
                        s_nxt.done = 1'b1;                         // R9
                        s_nxt.ph = charge_pkg::ST_IDLE;
                    end else if (ms_pulse &&
                                 s_r.ms >= s_r.mon_ms - 14'h1) begin
                        s_nxt.ms = 14'h0;
                        s_nxt.ph = charge_pkg::ST_NI_CLOSE;        // R6
                    end
                end
                charge_pkg::ST_LI_FAST: begin
                    if (fast_exp) begin
                        s_nxt.tout = 1'b1;                         // R21
                        s_nxt.ph = charge_pkg::ST_IDLE;
                    end else if (s_r.vbat > s_r.pstart) begin      // R13
                        s_nxt.phase_ms = 17'h0;
                        s_nxt.phase_min = 7'h0;
                        s_nxt.ms = 14'h0;
                        s_nxt.open_ms = charge_pkg::OPEN_MIN_MS;
                        s_nxt.hi_cnt = 7'h0;
                        s_nxt.ph = charge_pkg::ST_LI_CLOSE;
                    end
                end
                charge_pkg::ST_LI_CLOSE: begin
                    if (pulse_exp) begin
                        s_nxt.tout = 1'b1;                         // R21
                        s_nxt.ph = charge_pkg::ST_IDLE;
                    end else if (s_r.vbat >= s_r.ovp) begin        // R16
                        s_nxt.ovp_hit = 1'b1;
                        s_nxt.ms = 14'h0;
                        s_nxt.ph = charge_pkg::ST_LI_OPEN;
                    end else if (ms_pulse &&
                                 s_r.ms == 14'(CLOSE_MS_I - 1)) begin
                        s_nxt.ms = 14'h0;
                        s_nxt.sample = 1'b1;
                        s_nxt.ph = charge_pkg::ST_LI_OPEN;         // R14
                    end
                end
                charge_pkg::ST_LI_OPEN: begin
                    if (pulse_exp) begin
                        s_nxt.tout = 1'b1;                         // R21
                        s_nxt.ph = charge_pkg::ST_IDLE;
                    end else if (ms_pulse &&
                                 s_r.ms >= s_r.open_ms - 14'h1) begin
                        s_nxt.ms = 14'h0;
                        // Open time grows 100 ms per period up to 10 s
                        if (s_r.open_ms < charge_pkg::OPEN_MAX_MS) begin
                            s_nxt.open_ms = s_r.open_ms +
                                charge_pkg::OPEN_MIN_MS;           // R14
                        end
                        if (s_r.vbat > s_r.lvl.high) begin
                            s_nxt.hi_cnt = s_r.hi_cnt + 7'h1;
                        end
                        if (s_r.vbat > s_r.lvl.high &&
                            s_r.hi_cnt + 7'h1 >= s_r.nper) begin
                            s_nxt.done = 1'b1;                     // R15
                            s_nxt.ph = charge_pkg::ST_IDLE;
                        end else begin
                            s_nxt.ph = charge_pkg::ST_LI_CLOSE;
                        end
                    end
                end
                default: s_nxt.ph = charge_pkg::ST_IDLE;
            endcase
        end
        // Temperature evaluation interval counter in ms
        if (!temp_bad) begin
            s_nxt.tcnt = 3'h0;
        end else if (ms_pulse && s_r.tcnt < s_r.tdelta) begin
            s_nxt.tcnt = s_r.tcnt + 3'h1;                          // R19
        end
        // Phase change restarts the ms time base
        s_nxt.tick = (ms_pulse || s_nxt.ph != s_r.ph) ? 32'h0 :
            s_r.tick + 32'h1;
        // Unplugging the charger rearms the end-of-charge latch
        if (!CHARGER_INPUT) begin
            s_nxt.done = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r <= '0;
            s_r.alg <= 1'b0;                                       // R1
            s_r.mon_ms <= charge_pkg::MON_MS_DEF;
            s_r.idle_ms <= charge_pkg::IDLE_MS_DEF;
            s_r.lvl.low <= charge_pkg::MV_LOW_DEF;
            s_r.lvl.high <= charge_pkg::MV_HIGH_DEF;
            s_r.pstart <= charge_pkg::MV_PSTART_DEF;
            s_r.ovp <= charge_pkg::MV_OVP_DEF;
            s_r.fast_min <= charge_pkg::FAST_MIN_DEF;
            s_r.pulse_min <= charge_pkg::PULSE_MIN_DEF;
            s_r.twin.low <= charge_pkg::MV_THOT_DEF;
            s_r.twin.high <= charge_pkg::MV_TCOLD_DEF;
            s_r.tdelta <= charge_pkg::TDELTA_DEF;
            s_r.nper <= charge_pkg::N_PERIODS_DEF;
            s_r.ph <= charge_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // charge_ctrl

`default_nettype wire

//--- hw/charge_pkg.sv
// Package: constants and carrier types for the battery charge controller
package charge_pkg;

    // ---------------------------------------------------------------
    // Clock and time base
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_VBAT = 8'h08;
    localparam logic [7:0] OFS_THERM = 8'h0C;
    localparam logic [7:0] OFS_MONTIME = 8'h10;
    localparam logic [7:0] OFS_IDLETIME = 8'h14;
    localparam logic [7:0] OFS_BATLVL = 8'h18;
    localparam logic [7:0] OFS_PULSEV = 8'h1C;
    localparam logic [7:0] OFS_LIMITS = 8'h20;
    localparam logic [7:0] OFS_TEMPWIN = 8'h24;
    localparam logic [7:0] OFS_TDELTA = 8'h28;

    // ---------------------------------------------------------------
    // Field values
    // ---------------------------------------------------------------
    localparam logic [1:0] ALG_NICKEL = 2'h0;
    localparam logic [1:0] ALG_LITHIUM = 2'h1;
    localparam logic [1:0] ALG_QUERY = 2'h2;

    // ---------------------------------------------------------------
    // Voltages in mV
    // ---------------------------------------------------------------
    localparam logic [12:0] MV_TRICKLE = 13'h0AF0;   // 2800
    localparam logic [12:0] MV_ACTIVE = 13'h0C80;    // 3200
    localparam logic [12:0] MV_LOW_DEF = 13'h0D48;   // 3400
    localparam logic [12:0] MV_HIGH_DEF = 13'h1068;  // 4200
    localparam logic [12:0] MV_PSTART_DEF = 13'h0FA0; // 4000
    localparam logic [12:0] MV_OVP_DEF = 13'h1200;   // 4608
    localparam logic [12:0] MV_THOT_DEF = 13'h038C;  // 908
    localparam logic [12:0] MV_TCOLD_DEF = 13'h087B; // 2171

    // ---------------------------------------------------------------
    // Times in ms / minutes
    // ---------------------------------------------------------------
    localparam int CLOSE_MS = 1000;
    localparam logic [13:0] MON_MS_DEF = 14'h0064;   // 100
    localparam logic [13:0] IDLE_MS_DEF = 14'h1388;  // 5000
    localparam logic [13:0] OPEN_MIN_MS = 14'h0064;  // 100
    localparam logic [13:0] OPEN_MAX_MS = 14'h2710;  // 10000
    localparam logic [6:0] FAST_MIN_DEF = 7'h5A;     // 90
    localparam logic [6:0] PULSE_MIN_DEF = 7'h5A;    // 90
    localparam logic [2:0] TDELTA_DEF = 3'h3;
    localparam logic [6:0] N_PERIODS_DEF = 7'h0A;
    localparam int MIN_MS = 60000;
    localparam logic [7:0] POR_CTRL = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE, ST_TRICKLE, ST_PRE, ST_NI_CLOSE, ST_NI_OPEN,
        ST_LI_FAST, ST_LI_CLOSE, ST_LI_OPEN
    } phase_type;

    typedef struct packed {
        logic [12:0] low;
        logic [12:0] high;
    } window_type;

endpackage

//--- verif/battery_model.sv
// Battery and converter model feeding sampled voltage to the controller
`timescale 1ns/1ps
`default_nettype none
module battery_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_req,
    input wire logic [12:0] level_mv,
    output logic [12:0] vbat_mv,
    output logic vbat_valid
);
    // -------------------------------------------------------------
    // Converter
    // -------------------------------------------------------------
    logic [3:0] tick_r;
    logic fire;
    assign fire = sample_req || tick_r == 4'hF;
    // Periodic result plus one on request; between strobes the bus
    // shows the inverse so a stale capture cannot pass unnoticed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_r <= 4'h0;
            vbat_valid <= 1'b0;
            vbat_mv <= 13'h0;
        end else begin
            tick_r <= tick_r + 4'h1;
            vbat_valid <= fire;
            vbat_mv <= fire ? level_mv : ~level_mv;
        end
    end
endmodule // battery_model
`default_nettype wire

//--- verif/charge_checker.sv
// Checker: port-level properties of the charge controller
`timescale 1ns/1ps
`default_nettype none
module charge_checker #(
    parameter int TICK = 10,
    parameter int MS_PER_MIN = 20
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic CHARGER_INPUT,
    input wire logic [12:0] VBAT_MV,
    input wire logic VBAT_VALID,
    input wire logic SYSTEM_ACTIVE,
    input wire logic SWITCH_CLOSED,
    input wire logic PRECHARGE_EN,
    input wire logic SAMPLE_REQ
);
    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic [31:0] closed_cnt_r;
    // Length of the current closed run
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            closed_cnt_r <= 32'h0;
        end else begin
            closed_cnt_r <= SWITCH_CLOSED ? closed_cnt_r + 32'h1 : 32'h0;
        end
    end
    // Fresh sample, system down, charger present
    sequence s_cold;
        VBAT_VALID && CHARGER_INPUT && !SYSTEM_ACTIVE;
    endsequence
    sequence s_high_open;
        VBAT_VALID && VBAT_MV > 13'h1388 && !SWITCH_CLOSED;
    endsequence
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or error response");
    a_rdata_idle: assert property
        (!(HSEL && HREADY && HTRANS[1] && !HWRITE) |=> HRDATA == 32'h0)
        else $error("read data outside data phase");
    a_sample_pulse: assert property (SAMPLE_REQ |=> !SAMPLE_REQ)
        else $error("sample request longer than one cycle");
    a_trickle_open: assert property
        (s_cold ##0 VBAT_MV < charge_pkg::MV_TRICKLE |->
         ##[1:3] (!SWITCH_CLOSED && !PRECHARGE_EN))
        else $error("switch not open in trickle band");
    a_precharge_band: assert property
        (s_cold ##0 (VBAT_MV > charge_pkg::MV_TRICKLE &&
         VBAT_MV < charge_pkg::MV_ACTIVE) |-> ##[1:3] PRECHARGE_EN)
        else $error("no pre-charge in pre-charge band");
    a_unplug_open: assert property
        (!CHARGER_INPUT [*3] |-> !SWITCH_CLOSED && !PRECHARGE_EN)
        else $error("charging without charger");
    a_over_top: assert property
        (s_high_open |-> ##2 !SWITCH_CLOSED [*4])
        else $error("switch closed above top voltage");
    a_close_bound: assert property
        (closed_cnt_r <= 90 * MS_PER_MIN * TICK + 2)
        else $error("switch closed beyond fast limit");
endmodule // charge_checker
bind charge_ctrl charge_checker #(.TICK(TICK), .MS_PER_MIN(MS_PER_MIN))
    u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CHARGER_INPUT(CHARGER_INPUT),
    .VBAT_MV(VBAT_MV), .VBAT_VALID(VBAT_VALID),
    .SYSTEM_ACTIVE(SYSTEM_ACTIVE), .SWITCH_CLOSED(SWITCH_CLOSED),
    .PRECHARGE_EN(PRECHARGE_EN), .SAMPLE_REQ(SAMPLE_REQ));
`default_nettype wire

//--- verif/tb_top.sv
// Testbench: register and charging scenarios for the charge controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // -------------------------------------------------------------
    // Bench
    // -------------------------------------------------------------
    localparam int TK = 10;
    localparam int MPM = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic chg = 1'b0;
    logic act = 1'b0;
    logic [12:0] lvl = 13'h0;
    logic [12:0] therm = 13'h05DC;
    logic [12:0] vbat;
    logic vvalid;
    logic sreq;
    logic sw;
    logic pre;
    logic [31:0] rd;
    int n;
    int failures = 0;
    int checks_done = 0;
    logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C,
        8'h20, 8'h24, 8'h28, 8'h40};
    logic [31:0] xv [10] = '{32'h0, 32'h0, 32'h64, 32'h1388, 32'h10680D48,
        32'h12000FA0, 32'h000A5A5A, 32'h087B038C, 32'h3, 32'h0};
    always #5 clk = ~clk;
    charge_ctrl #(.TICK(TK), .MS_PER_MIN(MPM)) dut (.CLK(clk), .RST(rst),
        .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .CHARGER_INPUT(chg),
        .VBAT_MV(vbat), .VBAT_VALID(vvalid), .THERMISTOR_SENSE(therm),
        .SYSTEM_ACTIVE(act), .SWITCH_CLOSED(sw), .PRECHARGE_EN(pre),
        .SAMPLE_REQ(sreq));
    battery_model u_bat (.clk(clk), .rst(rst), .sample_req(sreq),
        .level_mv(lvl), .vbat_mv(vbat), .vbat_valid(vvalid));
    // One single transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] wd, output logic [31:0] q);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Spans may slip up to two cycles at phase ends
    task automatic chk_span(input string nm, input int e, input int g);
        checks_done++;
        if (g < e - 2 || g > e + 2) begin
            failures++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // Cycles until the switch leaves level lv, bounded
    task automatic span(input logic lv, output int k);
        k = 0;
        while (sw === lv && k < 40000) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic settle(output logic [31:0] q);
        repeat (60) @(posedge clk);
        bus(8'h04, 1'b0, 32'h0, q);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog sized well past the longest sequence
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            bus(ofs[i], 1'b0, 32'h0, rd);
            chk("reg", xv[i], rd);
        end
        bus(8'h00, 1'b1, 32'h1, rd);
        bus(8'h00, 1'b1, 32'h2, rd);
        bus(8'h00, 1'b0, 32'h0, rd);
        chk("alg query", 32'h1, rd);
        bus(8'h00, 1'b1, 32'h3, rd);
        bus(8'h00, 1'b0, 32'h0, rd);
        chk("alg bad", 32'h1, rd);
        bus(8'h00, 1'b1, 32'h0, rd);
        chg <= 1'b1;
        lvl <= 13'h09C4;
        settle(rd);
        chk("trickle", 32'h08, rd & 32'h3F);
        lvl <= 13'h0BB8;
        settle(rd);
        chk("precharge", 32'h11, rd & 32'h3F);
        act <= 1'b1;
        lvl <= 13'h0CE4;
        span(1'b0, n);
        span(1'b1, n);
        chk_span("ni close", 1000 * TK, n);
        span(1'b0, n);
        chk_span("ni open", 100 * TK, n);
        lvl <= 13'h13EC;
        span(1'b1, n);
        settle(rd);
        chk("ni end", 32'h100, rd & 32'h302);
        chg <= 1'b0;
        lvl <= 13'h0CE4;
        bus(8'h00, 1'b1, 32'h1, rd);
        bus(8'h20, 1'b1, 32'h000A5A46, rd);
        bus(8'h04, 1'b1, 32'hF00, rd);
        chg <= 1'b1;
        span(1'b0, n);
        span(1'b1, n);
        chk_span("li fast", 70 * MPM * TK, n);
        settle(rd);
        chk("li timeout", 32'h200, rd & 32'h202);
        chg <= 1'b0;
        bus(8'h04, 1'b1, 32'hF00, rd);
        repeat (4) @(posedge clk);
        chg <= 1'b1;
        span(1'b0, n);
        therm <= 13'h0960;
        settle(rd);
        chk("li temp", 32'h400, rd & 32'h402);
        bus(8'h00, 1'b1, 32'h0, rd);
        chg <= 1'b0;
        repeat (4) @(posedge clk);
        chg <= 1'b1;
        span(1'b0, n);
        chk("ni no temp", 32'h1, {31'h0, sw});
        test_done();
    end
endmodule // tb_top
`default_nettype wire
